// ### core/spt_pkg.sv
// constants for the serial port with packet release triggers
// assumes a 40 mhz system clock and a 16-bit register port
package spt_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int OVS = 16;
  localparam int MS_HZ = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_HZ;
  localparam int NBAUD = 9;
  localparam int BAUD [NBAUD] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 57600, 115200};
  localparam int RXB_AW = 11;
  localparam int TXB_AW = 4;
  // register indices
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_BCNT = 4'h1;
  localparam logic [3:0] A_IDLE = 4'h2;
  localparam logic [3:0] A_FIRST = 4'h3;
  localparam logic [3:0] A_CMD = 4'h4;
  localparam logic [3:0] A_TXD = 4'h5;
  localparam logic [3:0] A_RXD = 4'h6;
  localparam logic [3:0] A_STAT = 4'h7;
  localparam logic [3:0] A_LEN = 4'h8;
  // control fields
  localparam int F_BAUD = 0;
  localparam int F_SEVEN = 4;
  localparam int F_PAR = 5;
  localparam int F_TWO = 7;
  localparam int F_FLOW = 8;
  localparam int F_EN_CNT = 10;
  localparam int F_EN_IDLE = 11;
  localparam int F_EN_FIRST = 12;
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD = 2'h2;
  localparam logic [1:0] FLOW_NONE = 2'h0;
  localparam logic [1:0] FLOW_HW = 2'h1;
  localparam logic [1:0] FLOW_SW = 2'h2;
  localparam logic [15:0] CTRL_RST = 16'h0c05;
  localparam logic [15:0] BCNT_RST = 16'h0080;
  localparam logic [15:0] BCNT_MAX = 16'h05b4;
  localparam logic [15:0] IDLE_RST = 16'h0000;
  localparam logic [15:0] FIRST_RST = 16'h0064;
  // command and status bits
  localparam int C_CLR_RX = 0;
  localparam int C_CLR_TX = 1;
  localparam int S_PERR = 3;
  localparam int S_FERR = 4;
  localparam int S_OVR = 5;
  localparam logic [7:0] XON = 8'h11;
  localparam logic [7:0] XOFF = 8'h13;
  localparam logic [10:0] RX_STOP_LVL = 11'h7e0;
  localparam logic [10:0] RX_GO_LVL = 11'h700;
endpackage

// ### core/spt_core.sv
// serial port core: framing, flow control, receive batching and release triggers
// assumes one 40 mhz clock, synchronous active-low reset, async rxd/cts pins
//
// What this block does
// R01: line rate 300 to 115200, default 9600
// R02: seven or eight data bits, default eight
// R03: parity none, even or odd, default none
// R04: even parity generated and checked
// R05: odd parity generated, violations flagged
// R06: one or two stop bits, default one
// R07: no flow control ignores and sends nothing
// R08: hardware mode: rts when able, obey cts
// R09: software mode: xoff/xon sent and obeyed
// R10: release when batch reaches byte count
// R11: release after idle ms since last char
// R12: release after ms since first char
// R13: receive clear empties receive buffer
// R14: transmit clear drops waiting send bytes
// R15: first trigger wins, all timers restart
// R16: millisecond tick from system clock
`timescale 1ns/100ps
module spt_core #(
  parameter int P_MS_CYCLES = spt_pkg::MS_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_rxd,
  input wire logic i_cts_n,
  output logic o_txd,
  output logic o_rts_n,
  output logic o_release,
  output logic [10:0] o_release_len
);
  localparam int RAW = spt_pkg::RXB_AW;
  localparam int TAW = spt_pkg::TXB_AW;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} spt_rx_type;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} spt_tx_type;

  logic [15:0] ctrl_r, ctrl_nxt, bcnt_r, bcnt_nxt, idle_cfg_r, idle_cfg_nxt;
  logic [15:0] first_cfg_r, first_cfg_nxt, rdata_nxt;
  logic [3:0] baud_sel;
  logic seven, two_stop, en_cnt, en_idle, en_first;
  logic [1:0] par_mode, flow;
  assign baud_sel = ctrl_r[spt_pkg::F_BAUD +: 4];
  assign seven = ctrl_r[spt_pkg::F_SEVEN];
  assign par_mode = ctrl_r[spt_pkg::F_PAR +: 2];
  assign two_stop = ctrl_r[spt_pkg::F_TWO];
  assign flow = ctrl_r[spt_pkg::F_FLOW +: 2];
  assign en_cnt = ctrl_r[spt_pkg::F_EN_CNT];
  assign en_idle = ctrl_r[spt_pkg::F_EN_IDLE];
  assign en_first = ctrl_r[spt_pkg::F_EN_FIRST];

  // pin synchronisers: a change counts once the second and third stages agree
  logic [2:0] rx_s_r, cts_s_r;
  logic rxd_f_r, cts_f_r;
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      rx_s_r <= 3'h7;
      cts_s_r <= 3'h7;
      rxd_f_r <= 1'b1;
      cts_f_r <= 1'b1;
    end
    else
    begin
      rx_s_r <= {rx_s_r[1:0], i_rxd};
      cts_s_r <= {cts_s_r[1:0], i_cts_n};
      if (rx_s_r[2] == rx_s_r[1])
        rxd_f_r <= rx_s_r[2];
      if (cts_s_r[2] == cts_s_r[1])
        cts_f_r <= cts_s_r[2];
    end
  end

  // oversample divisor table, one entry per selectable rate
  logic [13:0] div_tab [spt_pkg::NBAUD];
  genvar g;
  generate
    for (g = 0; g < spt_pkg::NBAUD; g++)
    begin : g_div
      assign div_tab[g] = 14'(spt_pkg::CLK_HZ / (spt_pkg::OVS * spt_pkg::BAUD[g]) - 1); // [R01]
    end
  endgenerate

  // 16x bit tick and millisecond tick
  logic [13:0] div_r, div_nxt;
  logic [15:0] ms_r, ms_nxt;
  logic ovs_tick, ms_tick;
  always_comb
  begin
    ovs_tick = (div_r >= div_tab[baud_sel]); // [R01]
    div_nxt = ovs_tick ? 14'h0000 : div_r + 14'h0001;
    ms_tick = (ms_r == 16'(P_MS_CYCLES - 1)); // [R16]
    ms_nxt = ms_tick ? 16'h0000 : ms_r + 16'h0001;
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      div_r <= 14'h0000;
      ms_r <= 16'h0000;
    end
    else
    begin
      div_r <= div_nxt;
      ms_r <= ms_nxt;
    end
  end

  // receive path, receive buffer and release triggers
  logic [7:0] rx_mem [2**RAW];
  logic [7:0] tx_mem [2**TAW];
  spt_rx_type rx_st_r, rx_st_nxt;
  logic [3:0] rx_sub_r, rx_sub_nxt;
  logic [2:0] rx_bit_r, rx_bit_nxt, nbits_m1;
  logic [7:0] rx_sh_r, rx_sh_nxt, rx_data;
  logic rx_perr_r, rx_perr_nxt, char_ok, is_flow, store, pop, fire, rx_full, clr_rx;
  logic [RAW-1:0] rx_wr_r, rx_wr_nxt, rx_rel_r, rx_rel_nxt, rx_rd_r, rx_rd_nxt, batch, used;
  logic [15:0] idle_ms_r, idle_ms_nxt, first_ms_r, first_ms_nxt, stat_clr;
  logic paused_r, paused_nxt, perr_r, perr_nxt, ferr_r, ferr_nxt, ovr_r, ovr_nxt;
  logic rel_nxt;
  logic [10:0] len_nxt;
  assign nbits_m1 = seven ? 3'h6 : 3'h7; // [R02]
  assign rx_data = seven ? {1'b0, rx_sh_r[7:1]} : rx_sh_r;
  assign batch = rx_wr_r - rx_rel_r;
  assign used = rx_wr_r - rx_rd_r;
  assign rx_full = (rx_wr_r + 11'h001) == rx_rd_r;
  assign clr_rx = i_wr && (i_addr == spt_pkg::A_CMD) && i_wdata[spt_pkg::C_CLR_RX];
  assign stat_clr = (i_wr && (i_addr == spt_pkg::A_STAT)) ? i_wdata : 16'h0000;
  assign pop = i_rd && (i_addr == spt_pkg::A_RXD) && (rx_rd_r != rx_rel_r);
  always_comb
  begin
    rx_st_nxt = rx_st_r;
    rx_sub_nxt = ovs_tick ? rx_sub_r + 4'h1 : rx_sub_r;
    rx_bit_nxt = rx_bit_r;
    rx_sh_nxt = rx_sh_r;
    rx_perr_nxt = rx_perr_r;
    char_ok = 1'b0;
    // clears go first so a same-cycle event sets the flag again
    perr_nxt = perr_r & ~stat_clr[spt_pkg::S_PERR];
    ferr_nxt = ferr_r & ~stat_clr[spt_pkg::S_FERR];
    ovr_nxt = ovr_r & ~stat_clr[spt_pkg::S_OVR];
    case (rx_st_r)
      RX_IDLE:
      begin
        rx_sub_nxt = 4'h0;
        if (!rxd_f_r)
          rx_st_nxt = RX_START;
      end
      RX_START:
        if (ovs_tick && rx_sub_r == 4'h7)
        begin
          rx_sub_nxt = 4'h0;
          rx_bit_nxt = 3'h0;
          rx_perr_nxt = 1'b0;
          rx_st_nxt = rxd_f_r ? RX_IDLE : RX_DATA; // glitch rejected
        end
      RX_DATA:
        if (ovs_tick && rx_sub_r == 4'hf)
        begin
          rx_sh_nxt = {rxd_f_r, rx_sh_r[7:1]};
          rx_bit_nxt = rx_bit_r + 3'h1;
          if (rx_bit_r == nbits_m1) // [R02]
            rx_st_nxt = (par_mode == spt_pkg::PAR_NONE) ? RX_STOP : RX_PAR; // [R03]
        end
      RX_PAR:
        if (ovs_tick && rx_sub_r == 4'hf)
        begin
          rx_perr_nxt = ((^rx_data) ^ rxd_f_r) != (par_mode == spt_pkg::PAR_ODD); // [R04] [R05]
          rx_st_nxt = RX_STOP;
        end
      RX_STOP:
        if (ovs_tick && rx_sub_r == 4'hf)
        begin
          rx_st_nxt = RX_IDLE;
          char_ok = rxd_f_r;
          perr_nxt = perr_nxt | rx_perr_r; // [R05]
          ferr_nxt = ferr_nxt | !rxd_f_r;
        end
      default:
        rx_st_nxt = RX_IDLE;
    endcase
    // flow characters steer the sender and are never buffered
    is_flow = (flow == spt_pkg::FLOW_SW) &&
              (rx_data == spt_pkg::XON || rx_data == spt_pkg::XOFF);
    paused_nxt = (flow == spt_pkg::FLOW_SW) && paused_r; // [R07]
    if (char_ok && is_flow)
      paused_nxt = (rx_data == spt_pkg::XOFF); // [R09]
    store = char_ok && !is_flow && !rx_full;
    ovr_nxt = ovr_nxt | (char_ok && !is_flow && rx_full);
    rx_wr_nxt = rx_wr_r + RAW'(store);
    rx_rd_nxt = rx_rd_r + RAW'(pop);
    rx_rel_nxt = rx_rel_r;
    idle_ms_nxt = idle_ms_r;
    if (store)
      idle_ms_nxt = 16'h0000;
    else if (ms_tick && idle_ms_r != 16'hffff)
      idle_ms_nxt = idle_ms_r + 16'h0001; // [R11]
    first_ms_nxt = first_ms_r;
    if (batch == 11'h000)
      first_ms_nxt = 16'h0000;
    else if (ms_tick && first_ms_r != 16'hffff)
      first_ms_nxt = first_ms_r + 16'h0001; // [R12]
    // any enabled trigger hands off the batch; a byte landing now opens the next one
    fire = (batch != 11'h000) &&
           ((en_cnt && {5'h00, batch} >= bcnt_r) || // [R10]
            (en_idle && idle_ms_r >= idle_cfg_r) || // [R11]
            (en_first && first_ms_r >= first_cfg_r)); // [R12] [R15]
    rel_nxt = fire;
    len_nxt = fire ? batch : o_release_len;
    if (fire)
    begin
      rx_rel_nxt = rx_wr_r; // [R15]
      idle_ms_nxt = 16'h0000;
      first_ms_nxt = 16'h0000;
    end
    if (clr_rx)
    begin
      rx_wr_nxt = '0; // [R13]
      rx_rel_nxt = '0;
      rx_rd_nxt = '0;
      idle_ms_nxt = 16'h0000;
      first_ms_nxt = 16'h0000;
      rel_nxt = 1'b0;
      len_nxt = o_release_len; // a suppressed release leaves the last length alone
    end
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      rx_st_r <= RX_IDLE;
      rx_sub_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_perr_r <= 1'b0;
      rx_wr_r <= '0;
      rx_rel_r <= '0;
      rx_rd_r <= '0;
      idle_ms_r <= 16'h0000;
      first_ms_r <= 16'h0000;
      paused_r <= 1'b0;
      perr_r <= 1'b0;
      ferr_r <= 1'b0;
      ovr_r <= 1'b0;
      o_release <= 1'b0;
      o_release_len <= 11'h000;
    end
    else
    begin
      rx_st_r <= rx_st_nxt;
      rx_sub_r <= rx_sub_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_perr_r <= rx_perr_nxt;
      rx_wr_r <= rx_wr_nxt;
      rx_rel_r <= rx_rel_nxt;
      rx_rd_r <= rx_rd_nxt;
      idle_ms_r <= idle_ms_nxt;
      first_ms_r <= first_ms_nxt;
      paused_r <= paused_nxt;
      perr_r <= perr_nxt;
      ferr_r <= ferr_nxt;
      ovr_r <= ovr_nxt;
      o_release <= rel_nxt;
      o_release_len <= len_nxt;
    end
  end

  // buffer storage, not reset; pointers say what is valid
  logic [TAW:0] tx_wr_r, tx_wr_nxt, tx_rd_r, tx_rd_nxt;
  logic push, tx_full, tx_empty;
  always_ff @(posedge i_ref_clk)
  begin
    if (store)
      rx_mem[rx_wr_r] <= rx_data;
    if (push)
      tx_mem[tx_wr_r[TAW-1:0]] <= i_wdata[7:0];
  end

  // transmit path with flow control
  spt_tx_type tx_st_r, tx_st_nxt;
  logic [4:0] tx_sub_r, tx_sub_nxt;
  logic [2:0] tx_bit_r, tx_bit_nxt;
  logic [7:0] tx_char_r, tx_char_nxt, tx_masked;
  logic xoff_sent_r, xoff_sent_nxt, txd_nxt, rts_nxt, want_xoff, want_xon, may_send, par_bit;
  logic clr_tx;
  assign tx_empty = (tx_wr_r == tx_rd_r);
  assign tx_full = ({~tx_wr_r[TAW], tx_wr_r[TAW-1:0]} == tx_rd_r);
  assign clr_tx = i_wr && (i_addr == spt_pkg::A_CMD) && i_wdata[spt_pkg::C_CLR_TX];
  assign tx_masked = seven ? {1'b0, tx_char_r[6:0]} : tx_char_r;
  assign par_bit = (^tx_masked) ^ (par_mode == spt_pkg::PAR_ODD); // [R04] [R05]
  always_comb
  begin
    tx_st_nxt = tx_st_r;
    tx_sub_nxt = ovs_tick ? tx_sub_r + 5'h01 : tx_sub_r;
    tx_bit_nxt = tx_bit_r;
    tx_char_nxt = tx_char_r;
    tx_rd_nxt = tx_rd_r;
    txd_nxt = o_txd;
    xoff_sent_nxt = (flow == spt_pkg::FLOW_SW) && xoff_sent_r;
    want_xoff = (flow == spt_pkg::FLOW_SW) && !xoff_sent_r && used >= spt_pkg::RX_STOP_LVL;
    want_xon = (flow == spt_pkg::FLOW_SW) && xoff_sent_r && used < spt_pkg::RX_GO_LVL;
    may_send = !((flow == spt_pkg::FLOW_HW) && cts_f_r) && // [R08]
               !((flow == spt_pkg::FLOW_SW) && paused_r); // [R09]
    // rts held low unless hardware mode sees the buffer nearly full
    rts_nxt = (flow == spt_pkg::FLOW_HW) && used >= spt_pkg::RX_STOP_LVL; // [R07] [R08]
    case (tx_st_r)
      TX_IDLE:
      begin
        txd_nxt = 1'b1;
        tx_sub_nxt = 5'h00;
        if (want_xoff || want_xon)
        begin
          tx_char_nxt = want_xoff ? spt_pkg::XOFF : spt_pkg::XON; // [R09]
          xoff_sent_nxt = want_xoff;
          tx_st_nxt = TX_START;
          txd_nxt = 1'b0;
        end
        else if (!tx_empty && may_send)
        begin
          tx_char_nxt = tx_mem[tx_rd_r[TAW-1:0]];
          tx_rd_nxt = tx_rd_r + 5'h01;
          tx_st_nxt = TX_START;
          txd_nxt = 1'b0;
        end
      end
      TX_START:
        if (ovs_tick && tx_sub_r == 5'h0f)
        begin
          tx_sub_nxt = 5'h00;
          tx_bit_nxt = 3'h0;
          txd_nxt = tx_char_r[0];
          tx_st_nxt = TX_DATA;
        end
      TX_DATA:
        if (ovs_tick && tx_sub_r == 5'h0f)
        begin
          tx_sub_nxt = 5'h00;
          tx_bit_nxt = tx_bit_r + 3'h1;
          txd_nxt = tx_char_r[tx_bit_nxt];
          if (tx_bit_r == nbits_m1) // [R02]
          begin
            tx_st_nxt = (par_mode == spt_pkg::PAR_NONE) ? TX_STOP : TX_PAR; // [R03]
            txd_nxt = (par_mode == spt_pkg::PAR_NONE) ? 1'b1 : par_bit;
          end
        end
      TX_PAR:
        if (ovs_tick && tx_sub_r == 5'h0f)
        begin
          tx_sub_nxt = 5'h00;
          txd_nxt = 1'b1;
          tx_st_nxt = TX_STOP;
        end
      TX_STOP:
        if (ovs_tick && tx_sub_r == (two_stop ? 5'h1f : 5'h0f)) // [R06]
          tx_st_nxt = TX_IDLE;
      default:
        tx_st_nxt = TX_IDLE;
    endcase
    // a character already on the line finishes; only waiting ones are dropped
    if (clr_tx)
      tx_rd_nxt = tx_wr_r; // [R14]
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      tx_st_r <= TX_IDLE;
      tx_sub_r <= 5'h00;
      tx_bit_r <= 3'h0;
      tx_char_r <= 8'h00;
      tx_rd_r <= '0;
      xoff_sent_r <= 1'b0;
      o_txd <= 1'b1;
      o_rts_n <= 1'b0;
    end
    else
    begin
      tx_st_r <= tx_st_nxt;
      tx_sub_r <= tx_sub_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_char_r <= tx_char_nxt;
      tx_rd_r <= tx_rd_nxt;
      xoff_sent_r <= xoff_sent_nxt;
      o_txd <= txd_nxt;
      o_rts_n <= rts_nxt;
    end
  end

  // register port: writes steer configuration, reads answer one cycle later
  assign push = i_wr && (i_addr == spt_pkg::A_TXD) && !tx_full;
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    bcnt_nxt = bcnt_r;
    idle_cfg_nxt = idle_cfg_r;
    first_cfg_nxt = first_cfg_r;
    tx_wr_nxt = tx_wr_r + 5'(push);
    rdata_nxt = 16'h0000;
    if (i_wr)
      case (i_addr)
        spt_pkg::A_CTRL:
        begin
          ctrl_nxt = i_wdata;
          if (i_wdata[3:0] >= 4'(spt_pkg::NBAUD))
            ctrl_nxt[3:0] = baud_sel; // unsupported rate keeps the old one
        end
        spt_pkg::A_BCNT:
          bcnt_nxt = (i_wdata == 16'h0000) ? 16'h0001 :
                     (i_wdata > spt_pkg::BCNT_MAX) ? spt_pkg::BCNT_MAX : i_wdata; // [R10]
        spt_pkg::A_IDLE: idle_cfg_nxt = i_wdata;
        spt_pkg::A_FIRST: first_cfg_nxt = i_wdata;
        default: ;
      endcase
    if (i_rd)
      case (i_addr)
        spt_pkg::A_CTRL: rdata_nxt = ctrl_r;
        spt_pkg::A_BCNT: rdata_nxt = bcnt_r;
        spt_pkg::A_IDLE: rdata_nxt = idle_cfg_r;
        spt_pkg::A_FIRST: rdata_nxt = first_cfg_r;
        spt_pkg::A_RXD: rdata_nxt = {7'h00, pop, pop ? rx_mem[rx_rd_r] : 8'h00};
        spt_pkg::A_STAT: rdata_nxt = {8'h00, cts_f_r, paused_r, ovr_r, ferr_r, perr_r,
                                      tx_empty, tx_full, rx_rd_r != rx_rel_r};
        spt_pkg::A_LEN: rdata_nxt = {5'h00, o_release_len};
        default: rdata_nxt = 16'h0000;
      endcase
  end
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_reset_n)
    begin
      ctrl_r <= spt_pkg::CTRL_RST;
      bcnt_r <= spt_pkg::BCNT_RST;
      idle_cfg_r <= spt_pkg::IDLE_RST;
      first_cfg_r <= spt_pkg::FIRST_RST;
      tx_wr_r <= '0;
      o_rdata <= 16'h0000;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      bcnt_r <= bcnt_nxt;
      idle_cfg_r <= idle_cfg_nxt;
      first_cfg_r <= first_cfg_nxt;
      tx_wr_r <= tx_wr_nxt;
      o_rdata <= rdata_nxt;
    end
  end

  // checks on the block's own outputs and internal state
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  chk_rts_idle: assert property (flow != spt_pkg::FLOW_HW |=> !o_rts_n) // [R07]
    else $error("rts deasserted outside hardware flow mode");
  chk_cts_stall: assert property (flow == spt_pkg::FLOW_HW && cts_f_r && tx_st_r == TX_IDLE
    |=> tx_st_r == TX_IDLE) // [R08]
    else $error("character started while cts deasserted");
  chk_xoff_pause: assert property (flow == spt_pkg::FLOW_SW && paused_r && !want_xoff
    && !want_xon && tx_st_r == TX_IDLE |=> tx_st_r == TX_IDLE) // [R09]
    else $error("character started while paused by xoff");
  chk_even_par: assert property (tx_st_r == TX_PAR && par_mode == spt_pkg::PAR_EVEN
    |-> o_txd == ^tx_masked) // [R04]
    else $error("even parity bit wrong");
  chk_odd_par: assert property (tx_st_r == TX_PAR && par_mode == spt_pkg::PAR_ODD
    |-> o_txd != ^tx_masked) // [R05]
    else $error("odd parity bit wrong");
  chk_stop_high: assert property (tx_st_r == TX_STOP |-> o_txd) // [R06]
    else $error("stop bit not high");
  chk_data_bits: assert property (tx_st_r == TX_DATA |-> tx_bit_r <= nbits_m1) // [R02]
    else $error("too many data bits");
  chk_cnt_fire: assert property (en_cnt && batch != 11'h000 && {5'h00, batch} >= bcnt_r
    && !clr_rx |=> o_release && o_release_len == $past(batch)) // [R10]
    else $error("byte count trigger missed");
  chk_idle_fire: assert property (en_idle && batch != 11'h000 && idle_ms_r >= idle_cfg_r
    && !clr_rx |=> o_release) // [R11]
    else $error("idle trigger missed");
  chk_first_fire: assert property (en_first && batch != 11'h000 && first_ms_r >= first_cfg_r
    && !clr_rx |=> o_release) // [R12]
    else $error("first character trigger missed");
  chk_trig_restart: assert property (o_release |-> idle_ms_r == 16'h0000
    && first_ms_r == 16'h0000 && batch <= 11'h001) // [R15]
    else $error("triggers not restarted after release");
  chk_rx_clear: assert property (clr_rx |=> rx_wr_r == '0 && rx_rd_r == '0 && !o_release) // [R13]
    else $error("receive buffer not emptied");
  chk_tx_clear: assert property (clr_tx |=> tx_empty) // [R14]
    else $error("send buffer not emptied");
  chk_ms_tick: assert property (ms_tick |=> !ms_tick) // [R16]
    else $error("millisecond tick too long");
  cov_release: cover property (o_release && en_cnt);
  cov_parity_err: cover property (rx_st_r == RX_STOP && rx_perr_r && char_ok);
  cov_xoff_pause: cover property (paused_r && !tx_empty);
endmodule

// ### bench/spt_term.sv
// behavioural remote terminal facing the serial port pins
// assumes the bench sets the frame format to match the device before traffic
`timescale 1ns/100ps
module spt_term #(
  parameter int BIT = 336
) (
  input wire logic clk,
  input wire logic i_line,
  output logic o_line,
  output logic o_cts_n
);
  int nb = 8;
  bit pen = 0;
  logic [7:0] rbyte;
  logic rpar;
  int rcnt = 0;
  int cyc = 0;
  int t_fall = 0;
  int gap = 0;
  // free clock count, used to time the spacing of frame starts
  always @(posedge clk)
    cyc++;
  // line idles high, cts starts asserted; bench may drop it to stall the device
  initial
  begin
    o_line = 1'b1;
    o_cts_n = 1'b0;
  end
  task automatic bitout(input logic v);
    o_line <= v;
    repeat (BIT) @(posedge clk);
  endtask
  // one frame, lsb first; bad flips the parity bit on purpose
  task automatic send(input logic [7:0] b, input int n, input logic [1:0] pm, input bit bad);
    logic p;
    p = (pm == 2'h2);
    @(posedge clk);
    bitout(1'b0);
    for (int k = 0; k < n; k++)
    begin
      bitout(b[k]);
      p = p ^ b[k];
    end
    if (pm != 2'h0)
      bitout(p ^ bad);
    bitout(1'b1);
  endtask
  // receiver samples mid bit; stops short of the stop bit's end
  always
  begin
    @(negedge i_line);
    gap = cyc - t_fall;
    t_fall = cyc;
    rbyte = 8'h00;
    repeat (BIT / 2) @(posedge clk);
    for (int k = 0; k < nb; k++)
    begin
      repeat (BIT) @(posedge clk);
      rbyte[k] = i_line;
    end
    if (pen)
    begin
      repeat (BIT) @(posedge clk);
      rpar = i_line;
    end
    repeat (BIT) @(posedge clk);
    rcnt++;
  end
endmodule

// ### bench/tb.sv
// self-checking bench for the serial port core at 115200 baud
// assumes P_MS_CYCLES of 20, so one ms is 20 clocks
`timescale 1ns/100ps
module tb;
  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [15:0] o_rdata;
  logic o_txd, o_rts_n, o_release, rxd, cts_n;
  logic [10:0] o_release_len;
  logic [15:0] v;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_rel = 0;
  int r0;
  spt_core #(.P_MS_CYCLES(20)) uut (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_rxd(rxd), .i_cts_n(cts_n), .o_txd(o_txd), .o_rts_n(o_rts_n),
    .o_release(o_release), .o_release_len(o_release_len));
  spt_term #(.BIT(336)) term (.clk(i_ref_clk), .i_line(o_txd), .o_line(rxd), .o_cts_n(cts_n));
  // 40 mhz clock
  always #12.5 i_ref_clk = ~i_ref_clk;
  // count release pulses, sampled at the edge
  always @(posedge i_ref_clk)
    if (o_release === 1'b1)
      n_rel <= n_rel + 1;
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  // a frame that never arrives counts as a mismatch
  task automatic wait_rx(input int c0);
    for (int k = 0; k < 8000 && term.rcnt == c0; k++) @(posedge i_ref_clk);
    chk("frame seen", 16'(term.rcnt != c0), 16'h0001);
  endtask
  task automatic wait_rel(input int c0);
    for (int k = 0; k < 8000 && n_rel == c0; k++) @(posedge i_ref_clk);
    #1 chk("release seen", 16'(n_rel - c0), 16'h0001);
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // watchdog sized well above the expected run of about 70k cycles
  initial
  begin
    repeat (99000) @(posedge i_ref_clk);
    n_mismatch++;
    end_sim();
  end
  // main sequence
  initial
  begin
    repeat (10) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    rd(spt_pkg::A_CTRL, v); chk("ctrl", v, 16'h0c05);
    rd(spt_pkg::A_BCNT, v); chk("bcnt", v, 16'h0080);
    rd(spt_pkg::A_IDLE, v); chk("idle", v, 16'h0000);
    rd(spt_pkg::A_FIRST, v); chk("first", v, 16'h0064);
    rd(4'h9, v); chk("unmapped", v, 16'h0000);
    chk("rts", {15'h0, o_rts_n}, 16'h0000);
    // flow none: cts deasserted by the terminal must not hold the byte
    wr(spt_pkg::A_CTRL, 16'h0c08);
    term.o_cts_n <= 1'b1;
    r0 = term.rcnt;
    wr(spt_pkg::A_TXD, 16'h00a5);
    wait_rx(r0); chk("tx 8n1", {8'h0, term.rbyte}, 16'h00a5);
    term.o_cts_n <= 1'b0;
    // two stop bits stretch back-to-back frame starts to eleven bit times
    wr(spt_pkg::A_CTRL, 16'h0c88);
    r0 = term.rcnt;
    wr(spt_pkg::A_TXD, 16'h0031);
    wr(spt_pkg::A_TXD, 16'h0032);
    wait_rx(r0);
    wait_rx(r0 + 1); chk("tx 8n2", {8'h0, term.rbyte}, 16'h0032);
    chk("stop gap", 16'((term.gap + 168) / 336), 16'h000b);
    // seven bits with even then odd parity; 0x35 has four ones
    for (int p = 1; p <= 2; p++)
    begin
      wr(spt_pkg::A_CTRL, 16'h0c18 | 16'(p << 5));
      term.nb = 7;
      term.pen = 1;
      r0 = term.rcnt;
      wr(spt_pkg::A_TXD, 16'h00b5);
      wait_rx(r0); chk("tx 7 bit", {8'h0, term.rbyte}, 16'h0035);
      chk("tx parity", {15'h0, term.rpar}, 16'(p == 2));
      r0 = n_rel;
      term.send(8'h35, 7, 2'(p), p == 2);
      wait_rel(r0); chk("len", {5'h0, o_release_len}, 16'h0001);
      rd(spt_pkg::A_STAT, v); chk("perr", {15'h0, v[3]}, 16'(p == 2));
      rd(spt_pkg::A_RXD, v); chk("rx 7 bit", v, 16'h0135);
      wr(spt_pkg::A_STAT, 16'h0008);
    end
    term.nb = 8;
    term.pen = 0;
    // byte count of two, with a receive clear after the first byte
    wr(spt_pkg::A_CTRL, 16'h0408);
    wr(spt_pkg::A_BCNT, 16'h0002);
    r0 = n_rel;
    term.send(8'h41, 8, 2'h0, 0);
    wr(spt_pkg::A_CMD, 16'h0001);
    term.send(8'h42, 8, 2'h0, 0);
    repeat (400) @(posedge i_ref_clk);
    chk("no release", 16'(n_rel - r0), 16'h0000);
    term.send(8'h43, 8, 2'h0, 0);
    wait_rel(r0); chk("len", {5'h0, o_release_len}, 16'h0002);
    rd(spt_pkg::A_RXD, v); chk("rx", v, 16'h0142);
    rd(spt_pkg::A_RXD, v); chk("rx", v, 16'h0143);
    // first-char timer of 200 ms against back-to-back bytes 168 ms apart
    wr(spt_pkg::A_CTRL, 16'h1008);
    wr(spt_pkg::A_FIRST, 16'h00c8);
    r0 = n_rel;
    fork
      repeat (3) term.send(8'h5a, 8, 2'h0, 0);
    join_none
    wait_rel(r0); chk("len", {5'h0, o_release_len}, 16'h0002);
    wait_rel(r0 + 1); chk("len", {5'h0, o_release_len}, 16'h0001);
    // hardware flow: stalled by cts, then the send buffer is cleared
    wr(spt_pkg::A_CTRL, 16'h0508);
    term.o_cts_n <= 1'b1;
    // let cts pass the pin filter before the first byte is pushed
    repeat (6) @(posedge i_ref_clk);
    r0 = term.rcnt;
    wr(spt_pkg::A_TXD, 16'h0055);
    wr(spt_pkg::A_TXD, 16'h0056);
    repeat (4000) @(posedge i_ref_clk);
    chk("tx held", 16'(term.rcnt - r0), 16'h0000);
    wr(spt_pkg::A_CMD, 16'h0002);
    term.o_cts_n <= 1'b0;
    repeat (4000) @(posedge i_ref_clk);
    chk("tx dropped", 16'(term.rcnt - r0), 16'h0000);
    rd(spt_pkg::A_STAT, v); chk("tx empty", {15'h0, v[2]}, 16'h0001);
    // software flow: xoff pauses, xon resumes
    wr(spt_pkg::A_CTRL, 16'h0608);
    term.send(spt_pkg::XOFF, 8, 2'h0, 0);
    wr(spt_pkg::A_TXD, 16'h0077);
    repeat (4000) @(posedge i_ref_clk);
    chk("paused", 16'(term.rcnt - r0), 16'h0000);
    term.send(spt_pkg::XON, 8, 2'h0, 0);
    wait_rx(r0); chk("resumed", {8'h0, term.rbyte}, 16'h0077);
    end_sim();
  end
endmodule
